// file: inc/rps_pkg.sv
// Constants of the remappable pin select multiplexer: register map, reset values, defaults.
// Assumes a 32-bit AHB-Lite register port with word-aligned byte addresses.
package rps_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned RPS_ADDR_W   = 12;
  localparam int unsigned RPS_NUM_PINS = 8;
  localparam int unsigned RPS_NUM_IN   = 4;
  localparam int unsigned RPS_NUM_OUT  = 4;
  localparam int unsigned RPS_NUM_FIX  = 2;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_ANALOG    = 12'h000;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_DIRECTION = 12'h004;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_LATCH     = 12'h008;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_PORT      = 12'h00c;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_PULL_UP   = 12'h010;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_PULL_DOWN = 12'h014;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_LOCK      = 12'h018;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_KEY       = 12'h01c;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_IMAP_BASE = 12'h040;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFF_OMAP_BASE = 12'h080;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int unsigned RPS_LOCK_BIT  = 0;
  localparam logic [31:0] RPS_UNLOCK_KEY = 32'h0000_5a5a;
  localparam logic [31:0] RPS_ANALOG_RST = 32'h0000_000f;
  localparam logic [31:0] RPS_RP_MASK    = 32'h0000_00ff;
  localparam logic        RPS_LOCK_RST   = 1'b0;
  localparam logic        RPS_DIR_RST    = 1'b1;

endpackage

// file: hdl/rps_pin_mux.sv
// Remappable pin select multiplexer with AHB-Lite register slave.
// Assumes all inputs synchronous to core_clk; pins are split into in/out/enable.
// Function
// - Remappable peripherals reach no pin until software assigns one.
// - Active remapped peripheral overrides all other digital functions on its pin.
// - Remapped peripherals never override an analog function on the pin.
// - Input and output maps are independent register sets.
// - A lock with key sequence blocks spurious map changes.
// - Only remappable pins accept input and output remapping, both ways.
// - Analog and dedicated-I/O modules are not routed through the mux.
// - After reset, analog-shared pins come up analog.
// - Analog pins disable the input buffer; port and latch reads give 0.
// - Output driver still works with direction output while analog.
// - Enabled higher-precedence fixed function disables all lower ones.
// - Each pin has its own pull-up and pull-down enable bit.
`timescale 1ns/1ps
`default_nettype none

module rps_pin_mux #(
  parameter int unsigned NP          = rps_pkg::RPS_NUM_PINS,
  parameter int unsigned NI          = rps_pkg::RPS_NUM_IN,
  parameter int unsigned NO          = rps_pkg::RPS_NUM_OUT,
  parameter int unsigned NF          = rps_pkg::RPS_NUM_FIX,
  parameter logic [31:0] ANALOG_MASK = rps_pkg::RPS_ANALOG_RST,
  parameter logic [31:0] RP_MASK     = rps_pkg::RPS_RP_MASK
) (
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          ce,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output var  logic                          hreadyout,
  output var  logic                          hresp,
  output var  logic [31:0]                   hrdata,
  input  wire logic [NP-1:0]                 pin_in,
  output var  logic [NP-1:0]                 pin_out,
  output var  logic [NP-1:0]                 pin_oe,
  output var  logic [NP-1:0]                 pin_ibuf_en,
  output var  logic [NP-1:0]                 pin_pull_up,
  output var  logic [NP-1:0]                 pin_pull_down,
  input  wire logic [NO-1:0]                 periph_out,
  input  wire logic [NO-1:0]                 periph_oe,
  output var  logic [NI-1:0]                 periph_in,
  input  wire logic [NP*NF-1:0]              fixed_en,
  input  wire logic [NP*NF-1:0]              fixed_out,
  input  wire logic [NP*NF-1:0]              fixed_oe
);
  import rps_pkg::*;

  localparam int unsigned IW = $clog2(NP + 1);
  localparam int unsigned OW = $clog2(NO + 1);
  localparam int unsigned AW = RPS_ADDR_W;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NP-1:0]         analog;
    logic [NP-1:0]         dir;
    logic [NP-1:0]         lat;
    logic [NP-1:0]         pu;
    logic [NP-1:0]         pd;
    logic [NP-1:0]         pin_in;
    logic [NP-1:0]         pin_out;
    logic [NP-1:0]         pin_oe;
    logic [NP-1:0]         ibuf;
    logic [NP-1:0]         pu_o;
    logic [NP-1:0]         pd_o;
    logic [NI-1:0]         per_in;
    logic [NI-1:0][IW-1:0] imap;
    logic [NP-1:0][OW-1:0] omap;
    logic                  locked;
    logic                  armed;
    logic                  rd_pend;
    logic                  wr_pend;
    logic [AW-1:0]         addr;
    logic                  hready;
    logic [31:0]           hrdata;
  } rps_state_t;

  rps_state_t s_q;
  rps_state_t s_d;

  // Map register index from an address, -1 when outside the map block
  function automatic int map_index(input logic [AW-1:0] a, input logic [AW-1:0] base,
                                   input int n);
    int idx;
    idx = -1;
    if (a >= base && a < base + AW'(4 * n) && a[1:0] == 2'b00) begin
      idx = int'((a - base) >> 2);
    end
    return idx;
  endfunction

  // First enabled fixed function of a pin, lowest index highest precedence
  function automatic int fixed_pick(input logic [NF-1:0] en);
    int k;
    k = -1;
    for (int f = NF - 1; f >= 0; f--) begin
      if (en[f]) begin
        k = f;
      end
    end
    return k;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic          take;
    int            ii;
    int            oi;
    int            sel;
    int            fk;
    logic [31:0]   rd;
    s_d  = s_q;
    take = hsel && htrans[1] && hready;
    ii   = -1;
    oi   = -1;
    sel  = 0;
    fk   = -1;
    rd   = 32'h0000_0000;

    // Write data phase, applied to the address taken earlier
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      s_d.armed   = 1'b0;
      ii = map_index(s_q.addr, RPS_OFF_IMAP_BASE, NI);
      oi = map_index(s_q.addr, RPS_OFF_OMAP_BASE, NP);
      unique case (s_q.addr)
        RPS_OFF_ANALOG:    s_d.analog = hwdata[NP-1:0];
        RPS_OFF_DIRECTION: s_d.dir    = hwdata[NP-1:0];
        RPS_OFF_LATCH:     s_d.lat    = hwdata[NP-1:0];
        RPS_OFF_PULL_UP:   s_d.pu     = hwdata[NP-1:0];
        RPS_OFF_PULL_DOWN: s_d.pd     = hwdata[NP-1:0];
        // lock sets freely, clears only right after key
        RPS_OFF_LOCK: begin
          if (hwdata[RPS_LOCK_BIT]) begin
            s_d.locked = 1'b1;
          end else if (s_q.armed) begin
            s_d.locked = 1'b0;
          end
        end
        RPS_OFF_KEY:       s_d.armed  = (hwdata == RPS_UNLOCK_KEY);
        default: begin
          // separate input and output map sets
          if (ii >= 0 && !s_q.locked) begin
            s_d.imap[ii] = hwdata[IW-1:0];
          end
          // output maps only exist on remappable pins
          if (oi >= 0 && !s_q.locked && RP_MASK[oi]) begin
            s_d.omap[oi] = hwdata[OW-1:0];
          end
        end
      endcase
    end

    // Read data phase, one wait state so earlier writes are seen
    if (s_q.rd_pend) begin
      ii = map_index(s_q.addr, RPS_OFF_IMAP_BASE, NI);
      oi = map_index(s_q.addr, RPS_OFF_OMAP_BASE, NP);
      unique case (s_q.addr)
        RPS_OFF_ANALOG:    rd = 32'(s_q.analog);
        RPS_OFF_DIRECTION: rd = 32'(s_q.dir);
        // analog pins read back as 0
        RPS_OFF_LATCH:     rd = 32'(s_q.lat & ~s_q.analog);
        RPS_OFF_PORT:      rd = 32'(s_q.pin_in & ~s_q.analog);
        RPS_OFF_PULL_UP:   rd = 32'(s_q.pu);
        RPS_OFF_PULL_DOWN: rd = 32'(s_q.pd);
        RPS_OFF_LOCK:      rd = 32'(s_q.locked);
        default: begin
          if (ii >= 0) begin
            rd = 32'(s_q.imap[ii]);
          end else if (oi >= 0) begin
            rd = 32'(s_q.omap[oi]);
          end
        end
      endcase
      s_d.hrdata  = rd;
      s_d.hready  = 1'b1;
      s_d.rd_pend = 1'b0;
    end

    // Address phase capture
    if (take) begin
      s_d.addr = haddr[AW-1:0];
      if (hwrite) begin
        s_d.wr_pend = 1'b1;
      end else begin
        s_d.rd_pend = 1'b1;
        s_d.hready  = 1'b0;
      end
    end

    // input buffer off on analog pins
    s_d.ibuf   = ~s_q.analog;
    s_d.pin_in = pin_in & ~s_q.analog;
    s_d.pu_o   = s_q.pu;
    s_d.pd_o   = s_q.pd;

    // Pin ownership: analog, then remap, then fixed precedence, then port
    for (int p = 0; p < NP; p++) begin
      sel = int'(s_q.omap[p]);
      fk  = fixed_pick(fixed_en[p*NF +: NF]);
      if (s_q.analog[p]) begin
        // port driver still usable in analog mode
        s_d.pin_out[p] = s_q.lat[p];
        s_d.pin_oe[p]  = ~s_q.dir[p];
      end else if (RP_MASK[p] && sel != 0 && sel <= NO) begin
        s_d.pin_out[p] = periph_out[sel-1];
        s_d.pin_oe[p]  = periph_oe[sel-1];
      end else if (fk >= 0) begin
        s_d.pin_out[p] = fixed_out[p*NF+fk];
        s_d.pin_oe[p]  = fixed_oe[p*NF+fk];
      end else begin
        s_d.pin_out[p] = s_q.lat[p];
        s_d.pin_oe[p]  = ~s_q.dir[p];
      end
    end

    // only digital remappable pins feed peripheral inputs
    for (int j = 0; j < NI; j++) begin
      sel = int'(s_q.imap[j]);
      if (sel != 0 && sel <= NP && RP_MASK[sel-1]) begin
        s_d.per_in[j] = s_q.pin_in[sel-1];
      end else begin
        s_d.per_in[j] = 1'b0;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // analog-shared pins reset to analog
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q        <= '0;
      s_q.analog <= ANALOG_MASK[NP-1:0];
      s_q.dir    <= {NP{RPS_DIR_RST}};
      s_q.ibuf   <= ~ANALOG_MASK[NP-1:0];
      s_q.locked <= RPS_LOCK_RST;
      s_q.hready <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register, except hresp tied to 0
  assign hreadyout     = s_q.hready;
  assign hresp         = 1'b0;
  assign hrdata        = s_q.hrdata;
  assign pin_out       = s_q.pin_out;
  assign pin_oe        = s_q.pin_oe;
  assign pin_ibuf_en   = s_q.ibuf;
  assign pin_pull_up   = s_q.pu_o;
  assign pin_pull_down = s_q.pd_o;
  assign periph_in     = s_q.per_in;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  logic [NP-1:0] nonrp_used;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      nonrp_used[p] = !RP_MASK[p] && (s_q.omap[p] != '0);
    end
  end

  a_no_default_in: assert property (ce && s_q.imap[0] == '0 |=> periph_in[0] == 1'b0)
    else $error("unassigned input reached peripheral");
  a_analog_keeps: assert property (ce && s_q.analog[0]
    |=> pin_oe[0] == !$past(s_q.dir[0]) && pin_out[0] == $past(s_q.lat[0]))
    else $error("analog pin taken by other function");
  a_lock_blocks: assert property (ce && s_q.locked && s_q.wr_pend
    |=> s_q.omap == $past(s_q.omap) && s_q.imap == $past(s_q.imap))
    else $error("map changed while locked");
  // lock clear needs the key first
  a_unlock_key: assert property (ce && s_q.locked && s_q.wr_pend && !s_q.armed
    |=> s_q.locked)
    else $error("lock cleared without key");
  // write to first input map register leaves output map
  a_maps_indep: assert property (ce && s_q.wr_pend && s_q.addr == RPS_OFF_IMAP_BASE
    |=> s_q.omap == $past(s_q.omap))
    else $error("input map write changed output map");
  // no output map on fixed pins
  a_rp_only: assert property (nonrp_used == '0)
    else $error("output map set on non-remappable pin");
  a_reset_analog: assert property ($rose(resetn) |-> s_q.analog == ANALOG_MASK[NP-1:0])
    else $error("analog pins not analog after reset");
  a_ibuf_off: assert property (ce |=> (pin_ibuf_en & $past(s_q.analog)) == '0 &&
    (s_q.pin_in & $past(s_q.analog)) == '0)
    else $error("input buffer on for analog pin");
  a_pulls: assert property (ce ##1 ce |-> pin_pull_up == $past(s_q.pu, 1) &&
    pin_pull_down == $past(s_q.pd, 1))
    else $error("pull enables not applied");

  // Per-pin ownership checks, so every pin the scenarios use is watched
  for (genvar p = 0; p < NP; p++) begin : g_pin_chk
    a_remap_wins: assert property (ce && RP_MASK[p] && !s_q.analog[p]
      && s_q.omap[p] == OW'(1)
      |=> pin_out[p] == $past(periph_out[0]) && pin_oe[p] == $past(periph_oe[0]))
      else $error("remapped output lost the pin");
    a_fixed_prec: assert property (ce && !s_q.analog[p] && s_q.omap[p] == '0
      && fixed_en[p*NF] |=> pin_out[p] == $past(fixed_out[p*NF])
      && pin_oe[p] == $past(fixed_oe[p*NF]))
      else $error("lower fixed function took the pin");
  end

  c_read: cover property (s_q.rd_pend ##1 hreadyout);
  c_unlock: cover property (s_q.locked ##[1:20] !s_q.locked);
  c_remap: cover property (s_q.omap[0] != '0 && !s_q.analog[0]);
  c_fixed_on: cover property (fixed_en != '0 && pin_oe != '0);
  c_map_in: cover property (s_q.imap[0] != '0 && periph_in[0]);

endmodule // rps_pin_mux

`default_nettype wire

// file: verification/rps_pin_env.sv
// Pad model: works out each pin level from mux drive, outside drive and pulls.
// Assumes registered pin controls from the mux, all on core_clk.
`timescale 1ns/1ps
`default_nettype none

module rps_pin_env (
  input  wire logic       core_clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull_up,
  input  wire logic [7:0] pin_pull_down,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  output var  logic [7:0] pin_in
);
  logic [7:0] float_q = 8'h55;

  // Undriven unpulled pads toggle so no stale level is seen
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  // weak pulls only when nothing drives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] :
                  pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 : float_q[i];
    end
  end
endmodule // rps_pin_env

`default_nettype wire

// file: verification/remappable_pin_select_mux_tb.sv
// Self-checking bench of the pin mux over its AHB-Lite port.
// Assumes default mux parameters: 8 pins, 4 in, 4 out, 2 fixed slots.
`timescale 1ns/1ps
`default_nettype none

module remappable_pin_select_mux_tb;
  import rps_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hrdy, hresp;
  logic [7:0]  pin_in, pin_out, pin_oe, ibuf, pu, pd;
  logic [7:0]  ext_val = 8'h00;
  logic [7:0]  ext_drv = 8'h00;
  logic [3:0]  p_out = 4'h0;
  logic [3:0]  p_oe = 4'h0;
  logic [3:0]  p_in;
  logic [15:0] f_en = 16'h0;
  logic [15:0] f_out = 16'h0;
  logic [15:0] f_oe = 16'h0;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  // ****
  // Design and pads
  // ****
  rps_pin_mux uut (.core_clk(core_clk), .resetn(resetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_ibuf_en(ibuf), .pin_pull_up(pu),
    .pin_pull_down(pd), .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in),
    .fixed_en(f_en), .fixed_out(f_out), .fixed_oe(f_oe));
  rps_pin_env env (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_up(pu), .pin_pull_down(pd), .ext_val(ext_val), .ext_drv(ext_drv),
    .pin_in(pin_in));

  // Clock and hang guard
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; read data kept in rd
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hrdy !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hrdy !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Let register and pin pipeline land; outputs are read before this edge moves them
  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rchk(RPS_OFF_ANALOG, 32'h0000_000f);
    chk({24'h0, ibuf}, 32'h0000_00f0);
    rchk(RPS_OFF_DIRECTION, 32'h0000_00ff);
    chk({28'h0, p_in}, 32'h0);
    rchk(RPS_OFF_LOCK, 32'h0);
    rchk(12'h3fc, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_analog;
    ext_drv <= 8'hff;
    ext_val <= 8'hff;
    bus(1'b1, RPS_OFF_LATCH, 32'hff);
    settle();
    rchk(RPS_OFF_PORT, 32'h0000_00f0);
    rchk(RPS_OFF_LATCH, 32'h0000_00f0);
    chk({24'h0, pin_oe}, 32'h0);
    bus(1'b1, RPS_OFF_DIRECTION, 32'h0);
    settle();
    chk({16'h0, pin_oe, pin_out}, 32'h0000_ffff);
    bus(1'b1, RPS_OFF_DIRECTION, 32'hff);
    $display("t_analog done");
  endtask

  task automatic t_remap;
    ext_drv <= 8'h00;
    // clear analog select before digital use
    bus(1'b1, RPS_OFF_ANALOG, 32'h0);
    p_out <= 4'h1;
    p_oe <= 4'hf;
    f_en <= 16'h0010;
    f_oe <= 16'h0010;
    settle();
    chk({30'h0, pin_oe[2], pin_out[2]}, 32'h2);
    bus(1'b1, RPS_OFF_OMAP_BASE + 12'h008, 32'h1);
    settle();
    chk({30'h0, pin_oe[2], pin_out[2]}, 32'h3);
    bus(1'b1, RPS_OFF_ANALOG, 32'h1);
    bus(1'b1, RPS_OFF_OMAP_BASE, 32'h1);
    settle();
    chk({31'h0, pin_oe[0]}, 32'h0);
    $display("t_remap done");
  endtask

  task automatic t_prio;
    f_en <= 16'h0c10;
    f_oe <= 16'h0c10;
    f_out <= 16'h0800;
    settle();
    chk({30'h0, pin_oe[5], pin_out[5]}, 32'h2);
    f_en <= 16'h0810;
    settle();
    chk({30'h0, pin_oe[5], pin_out[5]}, 32'h3);
    $display("t_prio done");
  endtask

  task automatic t_imap;
    ext_drv <= 8'h48;
    ext_val <= 8'h08;
    bus(1'b1, RPS_OFF_IMAP_BASE, 32'h4);
    bus(1'b1, RPS_OFF_IMAP_BASE + 12'h004, 32'h7);
    bus(1'b1, RPS_OFF_IMAP_BASE + 12'h008, 32'h1);
    settle();
    chk({28'h0, p_in}, 32'h1);
    ext_val <= 8'h40;
    settle();
    chk({28'h0, p_in}, 32'h2);
    $display("t_imap done");
  endtask

  task automatic t_lock;
    bus(1'b1, RPS_OFF_LOCK, 32'h1);
    bus(1'b1, RPS_OFF_OMAP_BASE + 12'h010, 32'h2);
    chk({31'h0, hresp}, 32'h0);
    rchk(RPS_OFF_OMAP_BASE + 12'h010, 32'h0);
    bus(1'b1, RPS_OFF_LOCK, 32'h0);
    rchk(RPS_OFF_LOCK, 32'h1);
    bus(1'b1, RPS_OFF_KEY, RPS_UNLOCK_KEY);
    bus(1'b1, RPS_OFF_LOCK, 32'h0);
    rchk(RPS_OFF_LOCK, 32'h0);
    bus(1'b1, RPS_OFF_OMAP_BASE + 12'h010, 32'h2);
    rchk(RPS_OFF_OMAP_BASE + 12'h010, 32'h2);
    $display("t_lock done");
  endtask

  task automatic t_pull;
    bus(1'b1, RPS_OFF_PULL_UP, 32'h0a);
    bus(1'b1, RPS_OFF_PULL_DOWN, 32'h50);
    settle();
    chk({16'h0, pu, pd}, 32'h0000_0a50);
    rchk(RPS_OFF_PULL_UP, 32'h0000_000a);
    $display("t_pull done");
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_analog();
    t_remap();
    t_prio();
    t_imap();
    t_lock();
    t_pull();
    close_out();
  end
endmodule // remappable_pin_select_mux_tb

`default_nettype wire
